// File: src/spu_pkg.sv
// Purpose: Constants for the sensor power-state upload sequencer
// Assumes: 16-bit registers on 9-bit addresses, written over SPI
// Notes:   Addresses are register indices on the configuration port
package spu_pkg;
	localparam logic [8:0]  ADDR_COLOR_SEL     = 9'h002;
	localparam logic [8:0]  ADDR_CLK_GEN       = 9'h020;
	localparam logic [8:0]  ADDR_LOGIC_EN      = 9'h022;
	localparam logic [8:0]  ADDR_IMG_CORE      = 9'h028;
	localparam logic [8:0]  ADDR_AFE           = 9'h030;
	localparam logic [8:0]  ADDR_BIAS          = 9'h040;
	localparam logic [8:0]  ADDR_TX_BIAS       = 9'h044;
	localparam logic [8:0]  ADDR_TX            = 9'h070;
	localparam logic [8:0]  ADDR_SEQ_MODE      = 9'h0c0;
	localparam logic [8:0]  ADDR_ROT_SEL       = 9'h0c1;
	localparam logic [8:0]  ADDR_WIN_EN_LOW    = 9'h0c3;
	localparam logic [8:0]  ADDR_WIN_EN_HIGH   = 9'h0c4;
	localparam logic [8:0]  ADDR_RSV_FIRST     = 9'h029;
	localparam logic [15:0] RSV_FIRST_VALUE    = 16'h0b5a;
	localparam logic [15:0] ROT_NONZERO_VALUE  = 16'h8600;
	localparam logic [15:0] ROT_ZERO_VALUE     = 16'h0800;
	localparam logic [15:0] CLK_GEN_ON         = 16'h2005;
	localparam logic [15:0] CLK_GEN_OFF        = 16'h2004;
	localparam logic [15:0] TX_BIAS_ON         = 16'h0088;
	localparam logic [15:0] TX_ON              = 16'h0007;
	localparam logic [15:0] SEQ_ENABLE_VALUE   = 16'h000d;
	localparam logic [15:0] SEQ_DISABLE_VALUE  = 16'h000c;
	localparam logic [15:0] LOGIC_ON           = 16'h0001;
	localparam logic [15:0] LOGIC_OFF          = 16'h0000;
	localparam logic [15:0] SEQ_MODE_RESET     = 16'h0000;
	localparam logic [15:0] WIN_LOW_RESET      = 16'h0001;
	localparam logic [15:0] WIN_HIGH_RESET     = 16'h0000;
	localparam int          SEQ_EN_BIT         = 0;
	localparam int          SHUTTER_BIT        = 4;
	localparam int          SLAVE_BIT          = 5;
	localparam int          SUBSAMPLE_BIT      = 7;
	localparam int          BINNING_BIT        = 8;
	localparam int          SPI_CMD_BITS       = 26;
	localparam int          SETTLE_FRAMES      = 2;
	typedef enum logic [2:0] {
		SPU_OFF, SPU_STANDBY1, SPU_STANDBY2, SPU_IDLE, SPU_RUNNING
	} spu_state_t;
endpackage

// File: src/spu_sequencer.sv
// Purpose: Operating-state tracking of an image sensor driven by SPI
// Assumes: SPI frame = 9b address, 1b write, 16b data, MSB first
// Notes:   SPI pins are synchronised into the system clock domain
////////////////////////////////////////////////////////////////////////
module spu_sequencer
	import spu_pkg::*;
(
	input  wire logic        CLK_SYS_IN,
	input  wire logic        RESETN_IN,
	input  wire logic        SPI_SCLK_IN,
	input  wire logic        SPI_CSN_IN,
	input  wire logic        SPI_MOSI_IN,
	input  wire logic        FRAME_START_IN,
	output logic             SPI_MISO_OUT,
	output logic             SPI_MISO_OE_OUT,
	output logic [2:0]       STATE_OUT,
	output logic             LOGIC_CLK_EN_OUT,
	output logic [5:0]       BLOCK_EN_OUT,
	output logic             ACQUIRE_OUT,
	output logic             TRIGGERED_OUT,
	output logic             SLAVE_OUT,
	output logic             SUBSAMPLE_OUT,
	output logic             BINNING_OUT,
	output logic             ZERO_ROT_OUT,
	output logic             COLOR_OUT,
	output logic [31:0]      WINDOW_ACTIVE_OUT,
	output logic             SETTLING_OUT
);
	logic [2:0]  sclk_s_q, csn_s_q, mosi_s_q;
	logic [25:0] shift_q;
	logic [4:0]  bit_cnt_q;
	logic        wr_stb_q;
	logic [8:0]  wr_addr_q;
	logic [15:0] wr_data_q;
	logic [15:0] rd_data_q;
	logic        rd_frame_q;
	logic [15:0] seq_mode_q, win_low_q, win_high_q, rot_q;
	logic        color_q, logic_en_q;
	logic [5:0]  blocks_q;
	logic        rsv_done_q;
	logic [1:0]  settle_q;
	spu_state_t  state_q, state_d;

	// Read-back of the mode, rotation, window, logic-enable and colour registers; others read zero
	function automatic logic [15:0] read_reg(input logic [8:0] a);
		case (a)
			ADDR_SEQ_MODE:    read_reg = seq_mode_q;
			ADDR_ROT_SEL:     read_reg = rot_q;
			ADDR_WIN_EN_LOW:  read_reg = win_low_q;
			ADDR_WIN_EN_HIGH: read_reg = win_high_q;
			ADDR_LOGIC_EN:    read_reg = {15'h0000, logic_en_q};
			ADDR_COLOR_SEL:   read_reg = {15'h0000, color_q};
			default:          read_reg = 16'h0000;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers; only stages 1 and 2 feed logic
	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			sclk_s_q <= 3'h0;
			csn_s_q  <= 3'h7;
			mosi_s_q <= 3'h0;
		end else begin
			sclk_s_q <= {sclk_s_q[1:0], SPI_SCLK_IN};
			csn_s_q  <= {csn_s_q[1:0], SPI_CSN_IN};
			mosi_s_q <= {mosi_s_q[1:0], SPI_MOSI_IN};
		end
	end

	wire sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
	wire sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
	wire cs_act    = ~csn_s_q[1];

	// SPI shifter; write strobe after the 26th bit of a write frame
	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			shift_q   <= 26'h0000000;
			bit_cnt_q <= 5'h00;
			wr_stb_q  <= 1'b0;
			wr_addr_q <= 9'h000;
			wr_data_q <= 16'h0000;
		end else begin
			wr_stb_q <= 1'b0;
			if (!cs_act) begin
				bit_cnt_q <= 5'h00;
			end else if (sclk_rise) begin
				shift_q   <= {shift_q[24:0], mosi_s_q[1]};
				bit_cnt_q <= bit_cnt_q + 5'h01;
				if (bit_cnt_q == 5'(SPI_CMD_BITS - 1) && shift_q[15]) begin
					wr_stb_q  <= 1'b1;
					wr_addr_q <= shift_q[24:16];
					wr_data_q <= {shift_q[14:0], mosi_s_q[1]};
				end
			end
		end
	end

	// Read data loaded after address phase, shifted out on falling SCLK
	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			rd_data_q <= 16'h0000;
		end else if (cs_act && sclk_rise && bit_cnt_q == 5'h09) begin
			rd_data_q <= read_reg(shift_q[8:0]);
		end else if (cs_act && sclk_fall && bit_cnt_q > 5'h0a) begin
			rd_data_q <= {rd_data_q[14:0], 1'b0};
		end
	end

	// Read frame flag held from the W bit; later MOSI bits must not steer OE
	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
		if (!RESETN_IN)
			rd_frame_q <= 1'b0;
		else if (!cs_act)
			rd_frame_q <= 1'b0;
		else if (sclk_rise && bit_cnt_q == 5'h09)
			rd_frame_q <= ~mosi_s_q[1];
	end

	assign SPI_MISO_OUT    = rd_data_q[15];
	assign SPI_MISO_OE_OUT = cs_act & rd_frame_q; // Never during writes

	////////////////////////////////////////////////////////////////////
	// Mode register; bits are written only as a whole word
	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			seq_mode_q <= SEQ_MODE_RESET;
		end else if (wr_stb_q && wr_addr_q == ADDR_SEQ_MODE) begin
			seq_mode_q <= wr_data_q;
		end
	end

	// Window enables; taken in any powered state, full frame at reset
	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			win_low_q  <= WIN_LOW_RESET;
			win_high_q <= WIN_HIGH_RESET;
		end else if (wr_stb_q) begin
			if (wr_addr_q == ADDR_WIN_EN_LOW)
				win_low_q <= wr_data_q;
			if (wr_addr_q == ADDR_WIN_EN_HIGH)
				win_high_q <= wr_data_q;
		end
	end

	// Row-overhead choice and reserved upload progress
	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			rot_q      <= ROT_NONZERO_VALUE;
			rsv_done_q <= 1'b0;
		end else if (wr_stb_q) begin
			if (wr_addr_q == ADDR_ROT_SEL)
				rot_q <= wr_data_q;
			if (wr_addr_q == ADDR_RSV_FIRST && wr_data_q == RSV_FIRST_VALUE)
				rsv_done_q <= 1'b1;
		end
	end

	// Clock management and per-block enables, in write order
	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			color_q    <= 1'b0;
			logic_en_q <= 1'b0;
			blocks_q   <= 6'h00;
		end else if (wr_stb_q) begin
			case (wr_addr_q)
				ADDR_COLOR_SEL: color_q    <= wr_data_q[0];
				ADDR_LOGIC_EN:  logic_en_q <= (wr_data_q == LOGIC_ON);
				ADDR_CLK_GEN:   blocks_q[0] <= (wr_data_q == CLK_GEN_ON);
				ADDR_BIAS:      blocks_q[1] <= (wr_data_q != 16'h0000);
				ADDR_IMG_CORE:  blocks_q[2] <= (wr_data_q != 16'h0000);
				ADDR_AFE:       blocks_q[3] <= (wr_data_q != 16'h0000);
				ADDR_TX_BIAS:   blocks_q[4] <= (wr_data_q == TX_BIAS_ON);
				ADDR_TX:        blocks_q[5] <= (wr_data_q == TX_ON);
				default:        blocks_q   <= blocks_q;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Operating state from the enables
	always_comb begin
		state_d = state_q;
		case (state_q)
			SPU_OFF:      state_d = SPU_STANDBY1;
			SPU_STANDBY1: if (logic_en_q && rsv_done_q) state_d = SPU_STANDBY2;
			SPU_STANDBY2: begin
				if (!logic_en_q)       state_d = SPU_STANDBY1;
				else if (&blocks_q)    state_d = SPU_IDLE;
			end
			SPU_IDLE: begin
				if (!(&blocks_q))      state_d = SPU_STANDBY2;
				else if (seq_mode_q[SEQ_EN_BIT]) state_d = SPU_RUNNING;
			end
			SPU_RUNNING: begin
				if (!seq_mode_q[SEQ_EN_BIT]) state_d = SPU_IDLE;
				else if (!(&blocks_q))  state_d = SPU_STANDBY2;
			end
			default:      state_d = SPU_STANDBY1;
		endcase
	end

	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) state_q <= SPU_OFF;
		else            state_q <= state_d;
	end

	// Dynamic change in running keeps acquiring, flags a short transient
	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			settle_q <= 2'h0;
		end else if (wr_stb_q && state_q == SPU_RUNNING
				&& wr_addr_q != ADDR_SEQ_MODE) begin
			settle_q <= 2'(SETTLE_FRAMES);
		end else if (FRAME_START_IN && settle_q != 2'h0) begin
			settle_q <= settle_q - 2'h1;
		end
	end

	// Registered outputs; mode bits track the word as written
	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			STATE_OUT         <= 3'h0;
			LOGIC_CLK_EN_OUT  <= 1'b0;
			BLOCK_EN_OUT      <= 6'h00;
			ACQUIRE_OUT       <= 1'b0;
			TRIGGERED_OUT     <= 1'b0;
			SLAVE_OUT         <= 1'b0;
			SUBSAMPLE_OUT     <= 1'b0;
			BINNING_OUT       <= 1'b0;
			ZERO_ROT_OUT      <= 1'b0;
			COLOR_OUT         <= 1'b0;
			WINDOW_ACTIVE_OUT <= 32'h00000001;
			SETTLING_OUT      <= 1'b0;
		end else begin
			STATE_OUT         <= state_q;
			LOGIC_CLK_EN_OUT  <= logic_en_q;
			BLOCK_EN_OUT      <= blocks_q;
			ACQUIRE_OUT       <= (state_q == SPU_RUNNING);
			TRIGGERED_OUT     <= seq_mode_q[SHUTTER_BIT];
			SLAVE_OUT         <= seq_mode_q[SLAVE_BIT];
			SUBSAMPLE_OUT     <= seq_mode_q[SUBSAMPLE_BIT];
			BINNING_OUT       <= seq_mode_q[BINNING_BIT];
			ZERO_ROT_OUT      <= (rot_q == ROT_ZERO_VALUE);
			COLOR_OUT         <= color_q;
			WINDOW_ACTIVE_OUT <= {win_high_q, win_low_q};
			SETTLING_OUT      <= (settle_q != 2'h0);
		end
	end
endmodule

// File: tb/spu_host_model.sv
// Purpose: Behavioural SPI host that uploads sensor registers
// Assumes: Mode 0, 26-bit frames MSB first, W bit 1 write, 0 read
// Notes:   SCLK stands still low between frames
module spu_host_model (
	input  wire logic clk_in,
	input  wire logic miso_in,
	input  wire logic miso_oe_in,
	output logic      sclk_out,
	output logic      csn_out,
	output logic      mosi_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus: deselected, clock low
	initial begin
		sclk_out = 1'b0;
		csn_out  = 1'b1;
		mosi_out = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// Step off the edge so the device samples settled pins
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// Settle time after reset release, 10 us at 25 MHz
	task automatic power_on_wait();
		tick(250);
	endtask
	// Whole frame, then a deselect gap before any next frame
	task automatic spi_write(input logic [8:0] a, input logic [15:0] d);
		logic [25:0] f;
		f = {a, 1'b1, d};
		tick(1);
		csn_out = 1'b0;
		for (int i = 25; i >= 0; i--) begin
			mosi_out = f[i];
			tick(4); // Above the 3-clock floor
			sclk_out = 1'b1;
			tick(4);
			sclk_out = 1'b0;
		end
		tick(4);
		csn_out  = 1'b1;
		mosi_out = ~mosi_out; // No stale bit once released
		tick(8);
	endtask
	// Read frame; answer taken as SCLK rises, unknown while not driven
	task automatic spi_read(input logic [8:0] a, output logic [15:0] d);
		logic [25:0] f;
		f = {a, 1'b0, 16'h0000};
		d = 16'h0000;
		tick(1);
		csn_out = 1'b0;
		for (int i = 25; i >= 0; i--) begin
			mosi_out = f[i];
			tick(4);
			sclk_out = 1'b1;
			if (i < 16)
				d[i] = miso_oe_in ? miso_in : 1'bx;
			tick(4);
			sclk_out = 1'b0;
		end
		tick(4);
		csn_out  = 1'b1;
		mosi_out = ~mosi_out;
		tick(8);
	endtask
endmodule

// File: tb/spu_sequencer_props.sv
// Purpose: Port-level checker for the sequencer
// Assumes: One clock domain, async active-low reset
// Notes:   Bound onto every sequencer instance
module spu_sequencer_props
	import spu_pkg::*;
(
	input wire logic        CLK_SYS_IN,
	input wire logic        RESETN_IN,
	input wire logic [2:0]  STATE_OUT,
	input wire logic        LOGIC_CLK_EN_OUT,
	input wire logic [5:0]  BLOCK_EN_OUT,
	input wire logic        ACQUIRE_OUT,
	input wire logic        TRIGGERED_OUT,
	input wire logic        SLAVE_OUT,
	input wire logic        SUBSAMPLE_OUT,
	input wire logic        BINNING_OUT,
	input wire logic [31:0] WINDOW_ACTIVE_OUT,
	input wire logic        SETTLING_OUT
);
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RESETN_IN);
	////////////////////////////////////////////////////////////////////////
	// State moves; acquisition flag launched on the same edge as state
	a_acq_tracks_run: assert property (
		ACQUIRE_OUT == (STATE_OUT == SPU_RUNNING))
		else $error("acquire flag out of step with state");
	a_run_from_idle: assert property (
		$rose(STATE_OUT == SPU_RUNNING) |-> $past(STATE_OUT) == SPU_IDLE)
		else $error("running entered from a non-idle state");
	a_stop_to_idle: assert property (
		$fell(STATE_OUT == SPU_RUNNING) |-> STATE_OUT == SPU_IDLE)
		else $error("running left to a state other than idle");
	a_idle_all_blocks: assert property (
		$rose(STATE_OUT == SPU_IDLE) |-> $past(BLOCK_EN_OUT) == 6'h3f)
		else $error("idle reached without every block on");
	a_idle_clk_on: assert property (
		STATE_OUT inside {SPU_IDLE, SPU_RUNNING} |-> LOGIC_CLK_EN_OUT)
		else $error("idle or running without logic clocks");
	a_pd_leaves_idle: assert property (
		$past(STATE_OUT) == SPU_IDLE && STATE_OUT == SPU_STANDBY2
		|-> BLOCK_EN_OUT != 6'h3f) else $error("standby with all blocks on");
	a_settle_in_run: assert property (
		$rose(SETTLING_OUT) |-> STATE_OUT == SPU_RUNNING && ACQUIRE_OUT)
		else $error("transient flagged outside acquisition");
	// Values seen at the first edge after reset release
	a_win_reset_val: assert property (
		$rose(RESETN_IN) |-> WINDOW_ACTIVE_OUT == 32'h00000001)
		else $error("window enables wrong after reset");
	a_mode_reset_val: assert property (
		$rose(RESETN_IN) |-> {BINNING_OUT, SUBSAMPLE_OUT, SLAVE_OUT,
		TRIGGERED_OUT} == 4'h0) else $error("mode bits set after reset");
	c_run: cover property ($rose(STATE_OUT == SPU_RUNNING));
	c_settle: cover property ($rose(SETTLING_OUT));
	c_standby: cover property ($fell(STATE_OUT == SPU_IDLE));
endmodule
bind spu_sequencer spu_sequencer_props u_props (.CLK_SYS_IN, .RESETN_IN,
	.STATE_OUT, .LOGIC_CLK_EN_OUT, .BLOCK_EN_OUT, .ACQUIRE_OUT,
	.TRIGGERED_OUT, .SLAVE_OUT, .SUBSAMPLE_OUT, .BINNING_OUT,
	.WINDOW_ACTIVE_OUT, .SETTLING_OUT);

// File: tb/spu_sequencer_tb.sv
// Purpose: Self-checking bench for the sequencer state flow
// Assumes: Host model frames settle before each compare
// Notes:   Every wait is bounded
module spu_sequencer_tb
	import spu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
	logic        clk, rst_n, frame, acq, trig, slave, sub, bin, lclk, set;
	logic        zrot, color;
	logic [2:0]  state;
	logic [5:0]  blk;
	logic [31:0] win;
	wire         sclk, csn, mosi, miso, miso_oe;
	int          bad_count, num_checks;
	// Address, data, expected block enables after the write
	logic [30:0] up [6] = '{{ADDR_CLK_GEN, CLK_GEN_ON, 6'h01},
		{ADDR_BIAS, 16'h0001, 6'h03}, {ADDR_IMG_CORE, 16'h0003, 6'h07},
		{ADDR_AFE, 16'h0001, 6'h0f}, {ADDR_TX_BIAS, TX_BIAS_ON, 6'h1f},
		{ADDR_TX, TX_ON, 6'h3f}};
	logic [30:0] dn [5] = '{{ADDR_TX, 16'h0000, 6'h1f},
		{ADDR_AFE, 16'h0000, 6'h17}, {ADDR_IMG_CORE, 16'h0000, 6'h13},
		{ADDR_BIAS, 16'h0000, 6'h11}, {ADDR_CLK_GEN, CLK_GEN_OFF, 6'h10}};
	spu_host_model host (.clk_in(clk), .miso_in(miso),
		.miso_oe_in(miso_oe), .sclk_out(sclk), .csn_out(csn),
		.mosi_out(mosi));
	spu_sequencer uut (.CLK_SYS_IN(clk), .RESETN_IN(rst_n),
		.SPI_SCLK_IN(sclk), .SPI_CSN_IN(csn), .SPI_MOSI_IN(mosi),
		.FRAME_START_IN(frame), .SPI_MISO_OUT(miso),
		.SPI_MISO_OE_OUT(miso_oe),
		.STATE_OUT(state), .LOGIC_CLK_EN_OUT(lclk), .BLOCK_EN_OUT(blk),
		.ACQUIRE_OUT(acq), .TRIGGERED_OUT(trig), .SLAVE_OUT(slave),
		.SUBSAMPLE_OUT(sub), .BINNING_OUT(bin), .ZERO_ROT_OUT(zrot),
		.COLOR_OUT(color), .WINDOW_ACTIVE_OUT(win), .SETTLING_OUT(set));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Bounded wait; a miss ends the run at once
	task automatic wait_state(input spu_state_t s);
		for (int n = 0; n < 100 && state !== s; n++) @(posedge clk) #2;
		`CHK(state, s)
		if (state !== s) report_and_stop();
	endtask
	task automatic w(input logic [24:0] ad);
		host.spi_write(ad[24:16], ad[15:0]);
	endtask
	task automatic t_power_up();
		host.power_on_wait();
		w({ADDR_COLOR_SEL, 16'h0001});
		w({ADDR_LOGIC_EN, LOGIC_ON});
		`CHK({lclk, color}, 2'b11)
		w({ADDR_RSV_FIRST, RSV_FIRST_VALUE});
		w({9'h02a, 16'h1001});
		w({ADDR_ROT_SEL, ROT_ZERO_VALUE});
		`CHK(zrot, 1'b1)
		w({ADDR_ROT_SEL, ROT_NONZERO_VALUE});
		`CHK(zrot, 1'b0)
		wait_state(SPU_STANDBY2);
		// Ordered soft power-up, enables checked step by step
		foreach (up[i]) begin
			w(up[i][30:6]);
			`CHK(blk, up[i][5:0])
		end
		wait_state(SPU_IDLE);
		$display("test power_up done");
	endtask
	// Mode bits only while the sequencer is idle
	task automatic t_modes();
		logic [15:0] rd;
		w({ADDR_SEQ_MODE, 16'h01bc});
		`CHK({bin, sub, slave, trig}, 4'hf)
		host.spi_read(ADDR_SEQ_MODE, rd);
		`CHK(rd, 16'h01bc)
		`CHK(state, SPU_IDLE)
		w({ADDR_SEQ_MODE, SEQ_DISABLE_VALUE});
		`CHK({bin, sub, slave, trig}, 4'h0)
		$display("test modes done");
	endtask
	// Window switch mid-run; acquisition must not stop
	task automatic t_run();
		w({ADDR_SEQ_MODE, SEQ_ENABLE_VALUE});
		wait_state(SPU_RUNNING);
		w({ADDR_WIN_EN_LOW, 16'h0003});
		`CHK(win, 32'h00000003)
		`CHK({acq, set}, 2'b11)
		repeat (3) begin
			frame = 1'b1;
			@(posedge clk) #1 frame = 1'b0;
			repeat (10) @(posedge clk);
		end
		`CHK({acq, set}, 2'b10)
		$display("test run done");
	endtask
	task automatic t_stop();
		w({ADDR_SEQ_MODE, SEQ_DISABLE_VALUE});
		wait_state(SPU_IDLE);
		`CHK(acq, 1'b0)
		foreach (dn[i]) begin
			w(dn[i][30:6]);
			`CHK(blk, dn[i][5:0])
		end
		wait_state(SPU_STANDBY2);
		w({ADDR_LOGIC_EN, LOGIC_OFF});
		`CHK(lclk, 1'b0)
		wait_state(SPU_STANDBY1);
		$display("test stop done");
	endtask
	// Second reset after a full cycle; window set back to full frame
	task automatic t_reset();
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		wait_state(SPU_STANDBY1);
		`CHK(win, 32'h00000001)
		`CHK({lclk, blk, acq}, 8'h00)
		$display("test reset done");
	endtask
	// Reset, then the whole state flow and back down
	initial begin
		rst_n = 1'b0;
		frame = 1'b0;
		repeat (5) @(posedge clk);
		#1 rst_n = 1'b1;
		wait_state(SPU_STANDBY1);
		`CHK(win, 32'h00000001)
		`CHK({bin, sub, slave, trig}, 4'h0)
		t_power_up();
		t_modes();
		t_run();
		t_stop();
		t_reset();
		report_and_stop();
	end
endmodule
